// ===== design/sfc_regs.sv
// frame config register bank: wishbone slave, shadows and active settings
//
// Functional notes
// - bits 2..15 enable regions 18..31, reset 0
// - dark row count bits 7:0, range 1-255
// - bit 8 blanks first line, reset 1
// - padding rows bits 11:0, rolling only
// - time base multiplier, 68 MHz units, reset 1
// - duration is reset or frame length
// - duration select: 0 reset, 1 frame
// - exposure in lines or time base units
// - column gain 4:0, front-end gain 12:5
// - gain latency bit delays gain one frame when sync bit 4 is set
// - sync bits 0-2 defer line settings
// - sync bit 3 defers exposure updates
// - sync bit 4 defers gain updates
// - sync bit 5 defers region enable updates
// - bit 8 blanks frame after region change
// - bit 9 blanks after subsampling change
// - sync register resets to 0x033F
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_regs
  import sfc_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // ==========================================================
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // sequencer side
  input  wire logic        sof_i,
  output logic      [13:0] region_enable_o,
  output logic      [7:0]  dark_row_count_o,
  output logic             first_line_blank_o,
  output logic      [11:0] padding_row_count_o,
  output logic      [15:0] time_base_mult_o,
  output logic      [15:0] reset_length_o,
  output logic      [15:0] frame_length_o,
  output logic      [15:0] integration_lines_o,
  output logic      [15:0] integration_units_o,
  output logic      [4:0]  column_gain_o,
  output logic      [7:0]  frontend_gain_o,
  output logic      [11:0] digital_scale_factor_o,
  output logic      [8:0]  rolling_line_extension_o,
  output logic             rolling_shutter_o,
  output logic             blank_frame_o
);
  if (ADDR_W < 6) begin : g_bad_addr_w
    $error("sfc_regs: ADDR_W must be at least 6");
  end

  // ==========================================================
  // bus decode
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        req;
  logic        wr_en;
  logic [3:0]  idx;
  logic        hit;

  assign req   = wb_cyc_i & wb_stb_i & ~ack_r;
  assign idx   = wb_adr_i[5:2];
  assign hit   = ((wb_adr_i >> 6) == '0) && (idx >= `SFC_IDX_REGION_UPPER);
  assign wr_en = req & wb_we_i & hit;

  // merge the written byte lanes into the old word, keeping only writable bits
  function automatic sfc_word_t merge(input sfc_word_t old_v, input logic [15:0] msk);
    sfc_word_t v;
    v = old_v;
    if (wb_sel_i[0]) v[7:0]  = wb_dat_i[7:0];
    if (wb_sel_i[1]) v[15:8] = wb_dat_i[15:8];
    return v & msk;
  endfunction

  function automatic logic wr_to(input logic [3:0] i);
    return wr_en && (idx == i);
  endfunction

  // ==========================================================
  // software-visible shadow registers
  sfc_word_t region_r, dark_r, pad_r, tbase_r, dur_r, integ_r, again_r;
  sfc_word_t dscale_r, sync_r, mode_r;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      region_r <= `SFC_RST_REGION_UPPER;
      dark_r   <= `SFC_RST_DARK_ROW;
      pad_r    <= `SFC_RST_PADDING_ROW;
      tbase_r  <= `SFC_RST_TIME_BASE;
      dur_r    <= `SFC_RST_DURATION;
      integ_r  <= `SFC_RST_INTEGRATION;
      again_r  <= `SFC_RST_ANALOG_GAIN;
      dscale_r <= `SFC_RST_DIGITAL_SCALE;
      sync_r   <= `SFC_RST_SYNC_MASK;
      mode_r   <= `SFC_RST_MODE_CTRL;
    end else begin
      if (wr_to(`SFC_IDX_REGION_UPPER)) region_r <= merge(region_r, `SFC_MSK_REGION_UPPER);
      // a zero dark count is outside range and is refused, the old count stays
      if (wr_to(`SFC_IDX_DARK_ROW)) begin
        if (merge(dark_r, `SFC_MSK_DARK_ROW) != 16'h0000 && merge(dark_r, 16'h00FF) != 16'h0000)
          dark_r <= merge(dark_r, `SFC_MSK_DARK_ROW);
      end
      if (wr_to(`SFC_IDX_PADDING_ROW))   pad_r    <= merge(pad_r, `SFC_MSK_PADDING_ROW);
      if (wr_to(`SFC_IDX_TIME_BASE))     tbase_r  <= merge(tbase_r, 16'hFFFF);
      if (wr_to(`SFC_IDX_DURATION))      dur_r    <= merge(dur_r, 16'hFFFF);
      if (wr_to(`SFC_IDX_INTEGRATION))   integ_r  <= merge(integ_r, 16'hFFFF);
      if (wr_to(`SFC_IDX_ANALOG_GAIN))   again_r  <= merge(again_r, `SFC_MSK_ANALOG_GAIN);
      if (wr_to(`SFC_IDX_DIGITAL_SCALE)) dscale_r <= merge(dscale_r, `SFC_MSK_DIGITAL_SCALE);
      if (wr_to(`SFC_IDX_SYNC_MASK))     sync_r   <= merge(sync_r, `SFC_MSK_SYNC_MASK);
      if (wr_to(`SFC_IDX_MODE_CTRL))     mode_r   <= merge(mode_r, `SFC_MSK_MODE_CTRL);
    end
  end

  // ==========================================================
  // active copies, loaded the cycle after the write or at frame start per sync bit
  logic [13:0] region_act;
  sfc_word_t   dark_act, pad_act, expo_tb_act, expo_dur_act, expo_int_act, mode_act;
  logic        wr_region, wr_dark, wr_pad, wr_expo, wr_mode;

  assign wr_region = wr_to(`SFC_IDX_REGION_UPPER);
  assign wr_dark   = wr_to(`SFC_IDX_DARK_ROW);
  assign wr_pad    = wr_to(`SFC_IDX_PADDING_ROW);
  assign wr_mode   = wr_to(`SFC_IDX_MODE_CTRL);
  assign wr_expo   = wr_to(`SFC_IDX_TIME_BASE) | wr_to(`SFC_IDX_DURATION)
                   | wr_to(`SFC_IDX_INTEGRATION);

  // loading on the cycle after the write keeps the active copy equal to the shadow
  logic ld_region_r, ld_dark_r, ld_pad_r, ld_expo_r, ld_mode_r;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ld_region_r <= 1'b0;
      ld_dark_r   <= 1'b0;
      ld_pad_r    <= 1'b0;
      ld_expo_r   <= 1'b0;
      ld_mode_r   <= 1'b0;
    end else begin
      ld_region_r <= wr_region;
      ld_dark_r   <= wr_dark;
      ld_pad_r    <= wr_pad;
      ld_expo_r   <= wr_expo;
      ld_mode_r   <= wr_mode;
    end
  end

  sfc_shadow #(.WIDTH(14), .RST_VALUE(16'h0000)) u_region (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (ld_region_r),
    .shadow_i   (region_r[15:2]),
    .sync_i     (sync_r[`SFC_BIT_SYNC_ROI]),
    .sof_i      (sof_i),
    .active_o   (region_act)
  );
  sfc_shadow #(.WIDTH(16), .RST_VALUE(`SFC_RST_DARK_ROW)) u_dark (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (ld_dark_r),
    .shadow_i   (dark_r),
    .sync_i     (sync_r[`SFC_BIT_SYNC_DARK]),
    .sof_i      (sof_i),
    .active_o   (dark_act)
  );
  sfc_shadow #(.WIDTH(16), .RST_VALUE(`SFC_RST_PADDING_ROW)) u_pad (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (ld_pad_r),
    .shadow_i   (pad_r),
    .sync_i     (sync_r[`SFC_BIT_SYNC_PAD]),
    .sof_i      (sof_i),
    .active_o   (pad_act)
  );
  sfc_shadow #(.WIDTH(16), .RST_VALUE(`SFC_RST_TIME_BASE)) u_tbase (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (ld_expo_r),
    .shadow_i   (tbase_r),
    .sync_i     (sync_r[`SFC_BIT_SYNC_EXPO]),
    .sof_i      (sof_i),
    .active_o   (expo_tb_act)
  );
  sfc_shadow #(.WIDTH(16), .RST_VALUE(`SFC_RST_DURATION)) u_dur (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (ld_expo_r),
    .shadow_i   (dur_r),
    .sync_i     (sync_r[`SFC_BIT_SYNC_EXPO]),
    .sof_i      (sof_i),
    .active_o   (expo_dur_act)
  );
  sfc_shadow #(.WIDTH(16), .RST_VALUE(`SFC_RST_INTEGRATION)) u_integ (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (ld_expo_r),
    .shadow_i   (integ_r),
    .sync_i     (sync_r[`SFC_BIT_SYNC_EXPO]),
    .sof_i      (sof_i),
    .active_o   (expo_int_act)
  );
  // line extension lives in the mode word; it follows its own sync bit
  sfc_shadow #(.WIDTH(16), .RST_VALUE(`SFC_RST_MODE_CTRL)) u_mode (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (ld_mode_r),
    .shadow_i   (mode_r),
    .sync_i     (sync_r[`SFC_BIT_SYNC_LINEXT]),
    .sof_i      (sof_i),
    .active_o   (mode_act)
  );

  // ==========================================================
  // gain pipeline: optional extra frame of latency
  sfc_gain_e gain_st_r;
  logic [12:0] gain_pend_r;
  logic        gain_lat;
  assign gain_lat = again_r[`SFC_BIT_GAIN_LAT];

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gain_st_r       <= SFC_GAIN_IDLE;
      gain_pend_r     <= 13'h01E2;
      column_gain_o   <= 5'h02;
      frontend_gain_o <= 8'h0F;
    end else begin
      case (gain_st_r)
        SFC_GAIN_IDLE: begin
          if (wr_to(`SFC_IDX_ANALOG_GAIN)) begin
            gain_st_r <= SFC_GAIN_WAIT_SOF;
          end
        end
        SFC_GAIN_WAIT_SOF: begin
          gain_pend_r <= again_r[12:0];
          if (!sync_r[`SFC_BIT_SYNC_GAIN]) begin
            {frontend_gain_o, column_gain_o} <= again_r[12:0];
            gain_st_r <= SFC_GAIN_IDLE;
          end else if (sof_i) begin
            if (gain_lat) begin
              gain_st_r <= SFC_GAIN_DELAY_FRAME;
            end else begin
              {frontend_gain_o, column_gain_o} <= again_r[12:0];
              gain_st_r <= SFC_GAIN_IDLE;
            end
          end
        end
        SFC_GAIN_DELAY_FRAME: begin
          if (sof_i) begin
            {frontend_gain_o, column_gain_o} <= gain_pend_r;
            gain_st_r <= (wr_to(`SFC_IDX_ANALOG_GAIN) || again_r[12:0] != gain_pend_r)
                       ? SFC_GAIN_WAIT_SOF : SFC_GAIN_IDLE;
          end
        end
        default: gain_st_r <= SFC_GAIN_IDLE;
      endcase
    end
  end

  // ==========================================================
  // frame blanking after region or subsampling switches
  logic [13:0] region_prev_r;
  logic [1:0]  sub_prev_r;
  logic        blank_w;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      region_prev_r <= 14'h0000;
      sub_prev_r    <= 2'b00;
    end else begin
      region_prev_r <= region_act;
      sub_prev_r    <= {mode_act[`SFC_BIT_BINNING], mode_act[`SFC_BIT_SUBSAMPLE]};
    end
  end

  sfc_blank_ctrl u_blank (
    .core_clk_i      (core_clk_i),
    .rstn_i          (rstn_i),
    .sof_i           (sof_i),
    .region_change_i (region_prev_r != region_act),
    .sub_change_i    (sub_prev_r != {mode_act[`SFC_BIT_BINNING], mode_act[`SFC_BIT_SUBSAMPLE]}),
    .blank_roi_en_i  (sync_r[`SFC_BIT_BLANK_ROI]),
    .blank_sub_en_i  (sync_r[`SFC_BIT_BLANK_SUB]),
    .rolling_i       (mode_act[`SFC_BIT_SHUTTER_ROLL]),
    .blank_frame_o   (blank_w)
  );

  // ==========================================================
  // registered outputs to the sequencer
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      region_enable_o          <= 14'h0000;
      dark_row_count_o         <= 8'h02;
      first_line_blank_o       <= 1'b1;
      padding_row_count_o      <= 12'h000;
      time_base_mult_o         <= 16'h0001;
      reset_length_o           <= 16'h0000;
      frame_length_o           <= 16'h0000;
      integration_lines_o      <= 16'h0000;
      integration_units_o      <= 16'h0000;
      digital_scale_factor_o   <= 12'h080;
      rolling_line_extension_o <= 9'h000;
      rolling_shutter_o        <= 1'b0;
      blank_frame_o            <= 1'b0;
    end else begin
      region_enable_o    <= region_act;
      dark_row_count_o   <= dark_act[7:0];
      first_line_blank_o <= dark_act[`SFC_BIT_FIRST_LINE];
      // padding rows only matter under rolling shutter
      padding_row_count_o <= mode_act[`SFC_BIT_SHUTTER_ROLL] ? pad_act[11:0] : 12'h000;
      // time base and durations are passed on in both shutter modes
      time_base_mult_o <= expo_tb_act;
      reset_length_o   <= mode_act[`SFC_BIT_DUR_SELECT] ? 16'h0000 : expo_dur_act;
      frame_length_o   <= mode_act[`SFC_BIT_DUR_SELECT] ? expo_dur_act : 16'h0000;
      integration_lines_o <= mode_act[`SFC_BIT_SHUTTER_ROLL] ? expo_int_act : 16'h0000;
      integration_units_o <= mode_act[`SFC_BIT_SHUTTER_ROLL] ? 16'h0000 : expo_int_act;
      digital_scale_factor_o   <= dscale_r[11:0];
      rolling_line_extension_o <= {2'b00, mode_act[15:`SFC_BIT_LINE_EXT_LO]};
      rolling_shutter_o        <= mode_act[`SFC_BIT_SHUTTER_ROLL];
      blank_frame_o            <= blank_w;
    end
  end

  // ==========================================================
  // read mux and single-wait-state ack; spares and unmapped read zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req && !wb_we_i && hit) begin
        case (idx)
          `SFC_IDX_REGION_UPPER:  rdata_r <= {16'h0000, region_r};
          `SFC_IDX_DARK_ROW:      rdata_r <= {16'h0000, dark_r};
          `SFC_IDX_PADDING_ROW:   rdata_r <= {16'h0000, pad_r};
          `SFC_IDX_TIME_BASE:     rdata_r <= {16'h0000, tbase_r};
          `SFC_IDX_DURATION:      rdata_r <= {16'h0000, dur_r};
          `SFC_IDX_INTEGRATION:   rdata_r <= {16'h0000, integ_r};
          `SFC_IDX_ANALOG_GAIN:   rdata_r <= {16'h0000, again_r};
          `SFC_IDX_DIGITAL_SCALE: rdata_r <= {16'h0000, dscale_r};
          `SFC_IDX_SYNC_MASK:     rdata_r <= {16'h0000, sync_r};
          `SFC_IDX_MODE_CTRL:     rdata_r <= {16'h0000, mode_r};
          default:                rdata_r <= 32'h0000_0000;
        endcase
      end else if (req) begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
endmodule
`default_nettype wire

// ===== design/sfc_defs.svh
// register offsets, field positions, reset values and timing counts of the frame config bank
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
// word indices as printed; byte address is four times the index
`define SFC_IDX_REGION_UPPER  4'h4
`define SFC_IDX_DARK_ROW      4'h5
`define SFC_IDX_PADDING_ROW   4'h6
`define SFC_IDX_TIME_BASE     4'h7
`define SFC_IDX_DURATION      4'h8
`define SFC_IDX_INTEGRATION   4'h9
`define SFC_IDX_SPARE_A       4'hA
`define SFC_IDX_SPARE_B       4'hB
`define SFC_IDX_ANALOG_GAIN   4'hC
`define SFC_IDX_DIGITAL_SCALE 4'hD
`define SFC_IDX_SYNC_MASK     4'hE
`define SFC_IDX_MODE_CTRL     4'hF
// reset values
`define SFC_RST_REGION_UPPER  16'h0000
`define SFC_RST_DARK_ROW      16'h0102
`define SFC_RST_PADDING_ROW   16'h0000
`define SFC_RST_TIME_BASE     16'h0001
`define SFC_RST_DURATION      16'h0000
`define SFC_RST_INTEGRATION   16'h0000
`define SFC_RST_ANALOG_GAIN   16'h01E2
`define SFC_RST_DIGITAL_SCALE 16'h0080
`define SFC_RST_SYNC_MASK     16'h033F
`define SFC_RST_MODE_CTRL     16'h0004
// writable bit masks
`define SFC_MSK_REGION_UPPER  16'hFFFC
`define SFC_MSK_DARK_ROW      16'h01FF
`define SFC_MSK_PADDING_ROW   16'h0FFF
`define SFC_MSK_ANALOG_GAIN   16'h3FFF
`define SFC_MSK_DIGITAL_SCALE 16'h0FFF
`define SFC_MSK_SYNC_MASK     16'h033F
`define SFC_MSK_MODE_CTRL     16'hFF85
// field positions
`define SFC_BIT_FIRST_LINE    8
`define SFC_BIT_GAIN_LAT      13
`define SFC_BIT_SYNC_LINEXT   0
`define SFC_BIT_SYNC_DARK     1
`define SFC_BIT_SYNC_PAD      2
`define SFC_BIT_SYNC_EXPO     3
`define SFC_BIT_SYNC_GAIN     4
`define SFC_BIT_SYNC_ROI      5
`define SFC_BIT_BLANK_ROI     8
`define SFC_BIT_BLANK_SUB     9
`define SFC_BIT_SHUTTER_ROLL  0
`define SFC_BIT_DUR_SELECT    2
`define SFC_BIT_SUBSAMPLE     7
`define SFC_BIT_BINNING       8
`define SFC_BIT_LINE_EXT_LO   9
// timing: time base tick period as printed, 1/68 MHz
`define SFC_TIME_BASE_HZ      68000000
`endif

// ===== design/sfc_pkg.sv
// types shared by the frame config bank modules
package sfc_pkg;
  typedef logic [15:0] sfc_word_t;
  typedef enum logic [1:0] {
    SFC_GAIN_IDLE,
    SFC_GAIN_WAIT_SOF,
    SFC_GAIN_DELAY_FRAME
  } sfc_gain_e;
endpackage

// ===== design/sfc_shadow.sv
// shadow/active register pair with optional start-of-frame synchronisation
`timescale 1ns/1ps
`default_nettype none
module sfc_shadow #(
  parameter int          WIDTH     = 16,
  parameter logic [15:0] RST_VALUE = 16'h0000
) (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] shadow_i,
  input  wire logic             sync_i,
  input  wire logic             sof_i,
  output logic      [WIDTH-1:0] active_o
);
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("sfc_shadow: WIDTH must be 1..16");
  end

  // synced settings wait for frame start; otherwise they follow the write at once
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_o <= RST_VALUE[WIDTH-1:0];
    end else if (sync_i ? sof_i : load_i) begin
      active_o <= shadow_i;
    end
  end
endmodule
`default_nettype wire

// ===== design/sfc_blank_ctrl.sv
// decides whether the next frame is blanked after region or subsampling changes
`timescale 1ns/1ps
`default_nettype none
module sfc_blank_ctrl (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic sof_i,
  input  wire logic region_change_i,
  input  wire logic sub_change_i,
  input  wire logic blank_roi_en_i,
  input  wire logic blank_sub_en_i,
  input  wire logic rolling_i,
  output logic      blank_frame_o
);
  logic pend_roi_r;
  logic pend_sub_r;

  // change seen since last frame start; a change at the frame edge is kept
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_roi_r <= 1'b0;
      pend_sub_r <= 1'b0;
    end else begin
      pend_roi_r <= region_change_i | (pend_roi_r & ~sof_i);
      pend_sub_r <= sub_change_i | (pend_sub_r & ~sof_i);
    end
  end

  // rolling shutter always blanks after a subsampling or binning switch
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      blank_frame_o <= 1'b0;
    end else if (sof_i) begin
      blank_frame_o <= (pend_roi_r & blank_roi_en_i)
                     | (pend_sub_r & (blank_sub_en_i | rolling_i));
    end
  end
endmodule
`default_nettype wire

// ===== testbench/sfc_regs_asserts.sv
// assertion checker for the frame config register bank
`timescale 1ns/1ps
`default_nettype none
module sfc_regs_asserts #(
  parameter int ADDR_W = 6
) (
  input wire logic              core_clk_i,
  input wire logic              rstn_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic              sof_i,
  input wire logic [13:0]       region_enable_o,
  input wire logic [7:0]        dark_row_count_o,
  input wire logic [11:0]       padding_row_count_o,
  input wire logic [15:0]       reset_length_o,
  input wire logic [15:0]       frame_length_o,
  input wire logic [15:0]       integration_lines_o,
  input wire logic [15:0]       integration_units_o,
  input wire logic [4:0]        column_gain_o,
  input wire logic              rolling_shutter_o,
  input wire logic              blank_frame_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // mirror of the sync mask, since the checker cannot see inside
  logic [15:0] sync_r;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_r <= 16'h033f;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[5:2] == 4'he) begin
      sync_r <= wb_dat_i[15:0] & 16'h033f;
    end
  end
  // ==========================================================
  // assertions
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_DARK_NONZERO: assert property (dark_row_count_o != 8'h00)
    else $error("dark row count is zero");
  AST_PAD_ROLLING: assert property (!rolling_shutter_o && !$past(rolling_shutter_o)
    |-> padding_row_count_o == 12'h000) else $error("padding rows outside rolling mode");
  AST_DUR_SPLIT: assert property (reset_length_o == 16'h0000 || frame_length_o == 16'h0000)
    else $error("both duration outputs nonzero");
  AST_INTEG_SPLIT: assert property (integration_lines_o == 16'h0000
    || integration_units_o == 16'h0000) else $error("both exposure outputs nonzero");
  AST_DARK_SYNC: assert property (sync_r[1] && !$stable(dark_row_count_o)
    |-> $past(sof_i, 2)) else $error("synced dark count changed off frame start");
  AST_GAIN_SYNC: assert property (sync_r[4] && !$stable(column_gain_o)
    |-> $past(sof_i)) else $error("synced gain changed off frame start");
  AST_ROI_SYNC: assert property (sync_r[5] && !$stable(region_enable_o)
    |-> $past(sof_i, 2)) else $error("synced region enable changed off frame start");
  AST_BLANK_AT_SOF: assert property ($rose(blank_frame_o) |-> $past(sof_i, 2))
    else $error("blank raised off frame start");
  COV_WRITE: cover property (wb_ack_o && wb_we_i);
  COV_BLANK: cover property ($rose(blank_frame_o));
  COV_GAIN_SOF: cover property (sof_i && sync_r[4]);
endmodule
bind sfc_regs sfc_regs_asserts #(.ADDR_W(ADDR_W)) u_sfc_asserts (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .sof_i(sof_i), .region_enable_o(region_enable_o), .dark_row_count_o(dark_row_count_o),
  .padding_row_count_o(padding_row_count_o), .reset_length_o(reset_length_o),
  .frame_length_o(frame_length_o), .integration_lines_o(integration_lines_o),
  .integration_units_o(integration_units_o), .column_gain_o(column_gain_o),
  .rolling_shutter_o(rolling_shutter_o), .blank_frame_o(blank_frame_o));
`default_nettype wire

// ===== testbench/sfc_regs_test.sv
// self-checking testbench for the frame config register bank
`timescale 1ns/1ps
`default_nettype none
module sfc_regs_test;
  logic core_clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, sof_i;
  logic [5:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic wb_ack_o, first_line_blank_o, rolling_shutter_o, blank_frame_o;
  logic [13:0] region_enable_o;
  logic [7:0] dark_row_count_o, frontend_gain_o;
  logic [11:0] padding_row_count_o, digital_scale_factor_o;
  logic [15:0] time_base_mult_o, reset_length_o, frame_length_o;
  logic [15:0] integration_lines_o, integration_units_o;
  logic [4:0] column_gain_o;
  logic [8:0] rolling_line_extension_o;
  int error_cnt = 0;
  int check_count = 0;
  sfc_regs #(.ADDR_W(6)) dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sof_i(sof_i), .region_enable_o(region_enable_o), .dark_row_count_o(dark_row_count_o),
    .first_line_blank_o(first_line_blank_o), .padding_row_count_o(padding_row_count_o),
    .time_base_mult_o(time_base_mult_o), .reset_length_o(reset_length_o),
    .frame_length_o(frame_length_o), .integration_lines_o(integration_lines_o),
    .integration_units_o(integration_units_o), .column_gain_o(column_gain_o),
    .frontend_gain_o(frontend_gain_o), .digital_scale_factor_o(digital_scale_factor_o),
    .rolling_line_extension_o(rolling_line_extension_o),
    .rolling_shutter_o(rolling_shutter_o), .blank_frame_o(blank_frame_o));
  // ==========================================================
  // shared tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; holds everything until ack is sampled high
  task automatic xfer(input logic we, input logic [3:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd);
    int n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {16'h0000, wd};
    wb_sel_i <= 4'h3;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // unsynced writes land by the third edge after the request (gain and scale by the second); wait a bit more
  task automatic wr(input logic [3:0] idx, input logic [15:0] wd);
    logic [15:0] d;
    xfer(1'b1, idx, wd, d);
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    xfer(1'b0, idx, 16'h0000, d);
    chk(d, exp);
  endtask
  // one-cycle start-of-frame pulse, then let the active copy reach the outputs
  task automatic frame();
    @(posedge core_clk_i);
    sof_i <= 1'b1;
    @(posedge core_clk_i);
    sof_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [15:0] exp [16] = '{0, 0, 0, 0, 16'h0000, 16'h0102, 16'h0000, 16'h0001, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h01e2, 16'h0080, 16'h033f, 16'h0004};
    for (int i = 0; i < 16; i++) rd(i[3:0], exp[i]);
    chk(region_enable_o, 16'h0000);
    chk(dark_row_count_o, 16'h0002);
    chk(first_line_blank_o, 16'h0001);
    chk(time_base_mult_o, 16'h0001);
    chk({frontend_gain_o, column_gain_o}, 16'h01e2);
    chk(digital_scale_factor_o, 16'h0080);
    $display("test reset done");
  endtask
  task automatic t_region();
    logic seen;
    wr(4'h4, 16'h8007);
    rd(4'h4, 16'h8004);
    chk(region_enable_o, 16'h0000);
    frame();
    chk(region_enable_o, 16'h2001);
    seen = blank_frame_o;
    frame();
    seen |= blank_frame_o;
    chk(seen, 16'h0001);
    frame();
    chk(blank_frame_o, 16'h0000);
    $display("test region done");
  endtask
  task automatic t_dark();
    wr(4'h5, 16'h0100);
    rd(4'h5, 16'h0102);
    wr(4'he, 16'h0300);
    rd(4'he, 16'h0300);
    wr(4'h5, 16'h00ff);
    chk(dark_row_count_o, 16'h00ff);
    chk(first_line_blank_o, 16'h0000);
    $display("test dark done");
  endtask
  task automatic t_gain();
    wr(4'he, 16'h0310);
    wr(4'hc, 16'h2abf);
    rd(4'hc, 16'h2abf);
    frame();
    chk(column_gain_o, 16'h0002);
    frame();
    chk({frontend_gain_o, column_gain_o}, 16'h0abf);
    wr(4'hc, 16'h0021);
    chk(column_gain_o, 16'h001f);
    frame();
    chk({frontend_gain_o, column_gain_o}, 16'h0021);
    $display("test gain done");
  endtask
  task automatic t_mode();
    wr(4'he, 16'h0300);
    wr(4'h8, 16'h1234);
    wr(4'h9, 16'h0bcd);
    wr(4'h7, 16'habcd);
    frame();
    chk(frame_length_o, 16'h1234);
    chk(integration_units_o, 16'h0bcd);
    chk(time_base_mult_o, 16'habcd);
    wr(4'hf, 16'h0001);
    wr(4'h6, 16'hffff);
    frame();
    chk(reset_length_o, 16'h1234);
    chk(integration_lines_o, 16'h0bcd);
    chk(padding_row_count_o, 16'h0fff);
    wr(4'hf, 16'h8281);
    chk(rolling_line_extension_o, 16'h0041);
    chk(rolling_shutter_o, 16'h0001);
    frame();
    chk(blank_frame_o, 16'h0001);
    $display("test mode done");
  endtask
  task automatic t_spare();
    wr(4'ha, 16'hffff);
    rd(4'ha, 16'h0000);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h0000);
    wr(4'hd, 16'hffff);
    rd(4'hd, 16'h0fff);
    chk(digital_scale_factor_o, 16'h0fff);
    $display("test spare done");
  endtask
  // ==========================================================
  // clock, reset, sequence and watchdog
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    {rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, sof_i} = '0;
    wb_adr_i = '0;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_region();
    t_dark();
    t_gain();
    t_mode();
    t_spare();
    finish_test();
  end
  initial begin
    #(20000 * 25);
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
`default_nettype wire
